// file: rtl/cpu_regs_consts.vh
// shared constants for the cpu register banks and internal address map
`ifndef CPU_REGS_CONSTS_VH
`define CPU_REGS_CONSTS_VH

// software register port offsets
`define OFF_PSW 8'h00
`define OFF_PC 8'h01
`define OFF_SP 8'h02
`define OFF_MAP 8'h03
`define OFF_STAT 8'h04

// map select codes and 64k segments of the internal data area
`define MAP_LOW 4'h0
`define MAP_HIGH 4'hF
`define SEG_LOW 4'h0
`define SEG_HIGH 4'hF
`define SFR_START 16'hFF00

// general register banks sit in the top bytes of internal ram
`define BANK_AREA 128
`define BANK_COUNT 8
`define EXT_COUNT 32

// state word fields
`define PSW_CY 0
`define PSW_IE 3
`define PSW_AC 4
`define PSW_RSS 5
`define PSW_RBS 8
`define PSW_UF 12
`define PSW_MASK 16'h17FD
`define PSW_RST 16'h0000
`define PC_RST 20'h0_0000
`define SP_RST 24'h00_0000
`define SP_HI_MASK 24'hF0_0000

// access widths; an attribute holds {known, read, write, max width}
`define W_NONE 2'h0
`define W_BIT 2'h1
`define W_BYTE 2'h2
`define W_WORD 2'h3
`define ATTR_NONE 5'h00
`define ATTR_HALF 5'h10
`define ATTR_RW_B 5'h1E
`define ATTR_RW_W 5'h1F
`define ATTR_R_B 5'h1A
`define ATTR_R_W 5'h1B
`define A_KNOWN 4
`define A_RD 3
`define A_WR 2

`endif

// file: rtl/map_decoder.v
// internal data area decode and peripheral register attributes
`timescale 1ns/1ns
`include "cpu_regs_consts.vh"

module map_decoder #(
  parameter RAM_BYTES = 2048,
  parameter AW = 11
)(
  // address and placement
  input wire [19:0] addr,
  input wire fixed,
  input wire high,
  // decode results
  output reg hit_ram,
  output reg hit_sfr,
  output reg [AW-1:0] ram_idx,
  output reg [7:0] sfr_off,
  output reg [4:0] attr
);

  localparam integer RAM_START_I = `SFR_START - RAM_BYTES;
  localparam [15:0] RAM_START = RAM_START_I[15:0];

  reg in_area;
  reg [15:0] diff;

  //////////////////////////////////////////////////////////////////////
  // only part of the window is allocated; the rest deadlocks the core
  function [4:0] sfr_attr;
    input [7:0] off;
    begin
      case (off)
        8'h00, 8'h01, 8'h03, 8'h06, 8'h07, 8'h0E, 8'h0F,
        8'h20, 8'h21, 8'h23, 8'h26, 8'h27, 8'h2E,
        8'h30, 8'h31, 8'h32, 8'h33, 8'h41, 8'h43, 8'h4E:
          sfr_attr = `ATTR_RW_B;
        8'h02:
          sfr_attr = `ATTR_R_B;
        8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C,
        8'h36, 8'h38, 8'h3A:
          sfr_attr = `ATTR_RW_W;
        8'h50, 8'h52:
          sfr_attr = `ATTR_R_W;
        // upper halves: reachable only inside an even word access
        8'h11, 8'h13, 8'h15, 8'h17, 8'h19, 8'h1B, 8'h1D,
        8'h37, 8'h39, 8'h3B, 8'h51, 8'h53:
          sfr_attr = `ATTR_HALF;
        default:
          sfr_attr = `ATTR_NONE;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  always @*
  begin
    // no internal area until the placement has been fixed
    in_area = fixed &&
      (addr[19:16] == (high ? `SEG_HIGH : `SEG_LOW)); // see [RQ1] [RQ4]
    hit_sfr = in_area && (addr[15:0] >= `SFR_START); // see [RQ13] [RQ17]
    hit_ram = in_area && !hit_sfr &&
      (addr[15:0] >= RAM_START); // see [RQ3] [RQ4]
    diff = addr[15:0] - RAM_START;
    ram_idx = diff[AW-1:0];
    sfr_off = addr[7:0];
    attr = hit_sfr ? sfr_attr(addr[7:0]) : `ATTR_NONE; // see [RQ16]
  end

endmodule // map_decoder

// file: rtl/cpu_register_banks.v
// cpu register banks, control registers and internal address map
`timescale 1ns/1ns
`include "cpu_regs_consts.vh"
//////////////////////////////////////////////////////////////////////////
// How it works
// [RQ1] one-megabyte space decoded for every access
// [RQ2] placement chosen once after each reset
// [RQ3] option zero: data area below 10000H
// [RQ4] option F: data area at megabyte top
// [RQ5] sixteen bytes per set, pairs form words
// [RQ6] four pairs plus extension give pointers
// [RQ7] eight sets, chosen by software or switch
// [RQ8] general registers live in internal RAM
// [RQ9] alias flag opens legacy register names
// [RQ10] twenty-bit pointer advances with execution
// [RQ11] state word: bank, flags, bit one zero
// [RQ12] software keeps stack pointer top nibble zero
// [RQ13] peripheral window is top 256 bytes
// [RQ14] unallocated window access hangs until reset
// [RQ15] word peripheral access uses even address
// [RQ16] peripheral access type and width enforced
// [RQ17] option F adds F0000H to window addresses
// [RQ18] later placement selects are ignored

module cpu_register_banks #(
  parameter RAM_BYTES = 2048
)(
  // clock and reset
  input wire CLK,
  input wire RST,
  // software register port
  input wire [7:0] REG_ADDR,
  input wire [23:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output wire [23:0] REG_RDATA,
  // map select instruction
  input wire MAP_SEL,
  input wire [3:0] MAP_CODE,
  output wire MAP_FIXED,
  output wire MAP_HIGH,
  // memory access
  input wire MEM_RD,
  input wire MEM_WR,
  input wire [19:0] MEM_ADDR,
  input wire [1:0] MEM_SIZE,
  input wire [15:0] MEM_WDATA,
  output wire [15:0] MEM_RDATA,
  output wire RAM_HIT,
  output wire EXT_STB,
  output wire SFR_STB,
  output wire SFR_WE,
  output wire [7:0] SFR_OFF,
  output wire [15:0] SFR_WDATA,
  output wire SFR_ERR,
  output wire HANG,
  // general registers
  input wire GPR_RD,
  input wire GPR_WR,
  input wire GPR_WORD,
  input wire GPR_LEGACY,
  input wire [3:0] GPR_IDX,
  input wire [15:0] GPR_WDATA,
  output wire [15:0] GPR_RDATA,
  output wire GPR_ERR,
  // address extension and pointers
  input wire EXT_WR,
  input wire [1:0] EXT_SEL,
  input wire [7:0] EXT_WDATA,
  input wire [1:0] PTR_SEL,
  output wire [23:0] PTR_ADDR,
  // execution side
  input wire CTX_SW,
  input wire [2:0] CTX_BANK,
  input wire FLAG_WR,
  input wire [7:0] FLAG_DATA,
  input wire PC_LOAD,
  input wire [19:0] PC_TARGET,
  input wire [2:0] PC_STEP,
  output wire [19:0] PC_OUT,
  output wire [2:0] BANK
);

  localparam AW = $clog2(RAM_BYTES);
  localparam integer BANK_BASE_I = RAM_BYTES - `BANK_AREA;
  localparam [AW-1:0] BANK_BASE = BANK_BASE_I[AW-1:0];

  reg [7:0] ram [0:RAM_BYTES-1];
  reg [7:0] ext_ff [0:`EXT_COUNT-1];
  reg [15:0] psw_ff;
  reg [19:0] pc_ff;
  reg [23:0] sp_ff;
  reg map_fixed_ff;
  reg map_high_ff;
  reg hang_ff;
  reg [23:0] rdata_ff;
  reg [15:0] mem_rdata_ff;
  reg [15:0] gpr_rdata_ff;
  reg [23:0] ptr_ff;
  reg ram_hit_ff;
  reg ext_stb_ff;
  reg sfr_stb_ff;
  reg sfr_we_ff;
  reg sfr_err_ff;
  reg gpr_err_ff;
  reg [7:0] sfr_off_ff;
  reg [15:0] sfr_wdata_ff;
  reg [15:0] nxt_psw;
  reg [23:0] nxt_rdata;
  reg [4:0] gsel;
  reg gpr_ok;
  reg [AW-1:0] g_lo;
  reg [AW-1:0] g_hi;
  reg [AW-1:0] p_lo;
  reg [AW-1:0] p_hi;
  reg sfr_bad;
  integer i;

  wire dec_ram;
  wire dec_sfr;
  wire [AW-1:0] dec_idx;
  wire [7:0] dec_off;
  wire [4:0] dec_attr;
  wire [2:0] bank = psw_ff[`PSW_RBS +: 3];
  wire mem_go = (MEM_RD | MEM_WR) & ~hang_ff;
  wire word = (MEM_SIZE == `W_WORD);
  wire [AW-1:0] dec_hi = dec_idx + {{(AW-1){1'b0}}, 1'b1};
  wire sp_wide = |(sp_ff & `SP_HI_MASK);

  //////////////////////////////////////////////////////////////////////
  // {word, index} for the older register names
  function [4:0] legacy_map;
    input [2:0] code;
    begin
      case (code)
        3'h0: legacy_map = 5'h04;
        3'h1: legacy_map = 5'h05;
        3'h2: legacy_map = 5'h06;
        3'h3: legacy_map = 5'h07;
        3'h4: legacy_map = 5'h14;
        3'h5: legacy_map = 5'h16;
        default: legacy_map = 5'h04;
      endcase
    end
  endfunction

  // ram byte holding register r of bank b
  function [AW-1:0] gpr_addr;
    input [2:0] b;
    input [3:0] r;
    begin
      gpr_addr = BANK_BASE + {{(AW-7){1'b0}}, b, r}; // see [RQ8]
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  map_decoder #(
    .RAM_BYTES(RAM_BYTES),
    .AW(AW)
  ) u_dec (
    .addr(MEM_ADDR),
    .fixed(map_fixed_ff),
    .high(map_high_ff),
    .hit_ram(dec_ram),
    .hit_sfr(dec_sfr),
    .ram_idx(dec_idx),
    .sfr_off(dec_off),
    .attr(dec_attr)
  );

  //////////////////////////////////////////////////////////////////////
  always @*
  begin
    gsel = GPR_LEGACY ? legacy_map(GPR_IDX[2:0])
                      : {GPR_WORD, GPR_IDX}; // see [RQ9]
    // legacy names are dead while the alias flag is clear
    gpr_ok = ~GPR_LEGACY | psw_ff[`PSW_RSS]; // see [RQ9]
    g_lo = gpr_addr(bank, gsel[4] ? {gsel[3:1], 1'b0}
                                  : gsel[3:0]); // see [RQ5] [RQ7]
    g_hi = gpr_addr(bank, {gsel[3:1], 1'b1}); // see [RQ5]
    p_lo = gpr_addr(bank, {1'b1, PTR_SEL, 1'b0}); // see [RQ6]
    p_hi = gpr_addr(bank, {1'b1, PTR_SEL, 1'b1});
    sfr_bad = (MEM_SIZE > dec_attr[1:0]) |
              (MEM_RD & ~dec_attr[`A_RD]) |
              (MEM_WR & ~dec_attr[`A_WR]) |
              (word & dec_off[0]); // see [RQ15] [RQ16]
  end

  always @*
  begin
    nxt_psw = psw_ff;
    if (REG_WR && REG_ADDR == `OFF_PSW)
      nxt_psw = REG_WDATA[15:0] & `PSW_MASK; // see [RQ11]
    if (FLAG_WR)
      nxt_psw = {nxt_psw[15:8], FLAG_DATA} & `PSW_MASK; // see [RQ11]
    // a context switch overrides a bank written in the same cycle
    if (CTX_SW)
      nxt_psw[`PSW_RBS +: 3] = CTX_BANK; // see [RQ7]
  end

  always @*
  begin
    nxt_rdata = 24'h00_0000;
    case (REG_ADDR)
      `OFF_PSW: nxt_rdata[15:0] = psw_ff;
      `OFF_PC: nxt_rdata[19:0] = pc_ff;
      `OFF_SP: nxt_rdata = sp_ff;
      `OFF_MAP: nxt_rdata[1:0] = {map_high_ff, map_fixed_ff};
      `OFF_STAT: nxt_rdata[1:0] = {sp_wide, hang_ff}; // see [RQ12]
      default: nxt_rdata = 24'h00_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // control state
  always @(posedge CLK)
  begin
    if (RST)
    begin
      psw_ff <= `PSW_RST;
      pc_ff <= `PC_RST;
      sp_ff <= `SP_RST;
      map_fixed_ff <= 1'b0;
      map_high_ff <= 1'b0;
      hang_ff <= 1'b0;
      rdata_ff <= 24'h00_0000;
    end
    else
    begin
      psw_ff <= nxt_psw;
      if (PC_LOAD)
        pc_ff <= PC_TARGET;
      else
        pc_ff <= pc_ff + {17'h0_0000, PC_STEP}; // see [RQ10]
      if (REG_WR && REG_ADDR == `OFF_SP)
        sp_ff <= REG_WDATA;
      // unknown codes are ignored and leave the choice open
      if (MAP_SEL && !map_fixed_ff &&
          (MAP_CODE == `MAP_LOW || MAP_CODE == `MAP_HIGH))
      begin
        map_fixed_ff <= 1'b1; // see [RQ2] [RQ18]
        map_high_ff <= (MAP_CODE == `MAP_HIGH);
      end
      // only a reset clears a deadlock
      if (mem_go && dec_sfr && !dec_attr[`A_KNOWN])
        hang_ff <= 1'b1; // see [RQ14]
      rdata_ff <= REG_RD ? nxt_rdata : 24'h00_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // shared ram: data area and general registers alias
  // a register write beats a memory write to the same byte
  always @(posedge CLK)
  begin
    if (mem_go && MEM_WR && dec_ram)
    begin
      ram[dec_idx] <= MEM_WDATA[7:0]; // see [RQ8]
      if (word)
        ram[dec_hi] <= MEM_WDATA[15:8];
    end
    if (GPR_WR && gpr_ok)
    begin
      ram[g_lo] <= GPR_WDATA[7:0]; // see [RQ5] [RQ8]
      if (gsel[4])
        ram[g_hi] <= GPR_WDATA[15:8];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // access results, extension bytes and pointers
  always @(posedge CLK)
  begin
    if (RST)
    begin
      for (i = 0; i < `EXT_COUNT; i = i + 1)
        ext_ff[i] <= 8'h00;
      mem_rdata_ff <= 16'h0000;
      gpr_rdata_ff <= 16'h0000;
      ptr_ff <= 24'h00_0000;
      ram_hit_ff <= 1'b0;
      ext_stb_ff <= 1'b0;
      sfr_stb_ff <= 1'b0;
      sfr_we_ff <= 1'b0;
      sfr_err_ff <= 1'b0;
      gpr_err_ff <= 1'b0;
      sfr_off_ff <= 8'h00;
      sfr_wdata_ff <= 16'h0000;
    end
    else
    begin
      // extension bytes are flops, not ram
      if (EXT_WR)
        ext_ff[{bank, EXT_SEL}] <= EXT_WDATA; // see [RQ6] [RQ8]
      ptr_ff <= {ext_ff[{bank, PTR_SEL}], ram[p_hi], ram[p_lo]}; // see [RQ6]
      gpr_err_ff <= (GPR_RD | GPR_WR) & ~gpr_ok;
      if (GPR_RD && gpr_ok)
        gpr_rdata_ff <= {gsel[4] ? ram[g_hi] : 8'h00, ram[g_lo]};
      else
        gpr_rdata_ff <= 16'h0000;
      ram_hit_ff <= mem_go && dec_ram;
      ext_stb_ff <= mem_go && !dec_ram && !dec_sfr; // see [RQ1]
      sfr_stb_ff <= mem_go && dec_sfr && dec_attr[`A_KNOWN] && !sfr_bad;
      sfr_err_ff <= mem_go && dec_sfr && dec_attr[`A_KNOWN] &&
                    sfr_bad; // see [RQ16]
      // write strobe only for an accepted access, kept in its own flop
      sfr_we_ff <= mem_go && dec_sfr && dec_attr[`A_KNOWN] &&
                   !sfr_bad && MEM_WR; // see [RQ16]
      sfr_off_ff <= dec_off;
      sfr_wdata_ff <= MEM_WDATA;
      if (mem_go && MEM_RD && dec_ram)
        mem_rdata_ff <= {word ? ram[dec_hi] : 8'h00, ram[dec_idx]};
      else
        mem_rdata_ff <= 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign REG_RDATA = rdata_ff;
  assign MAP_FIXED = map_fixed_ff;
  assign MAP_HIGH = map_high_ff;
  assign MEM_RDATA = mem_rdata_ff;
  assign RAM_HIT = ram_hit_ff;
  assign EXT_STB = ext_stb_ff;
  assign SFR_STB = sfr_stb_ff;
  assign SFR_WE = sfr_we_ff;
  assign SFR_OFF = sfr_off_ff;
  assign SFR_WDATA = sfr_wdata_ff;
  assign SFR_ERR = sfr_err_ff;
  assign HANG = hang_ff;
  assign GPR_RDATA = gpr_rdata_ff;
  assign GPR_ERR = gpr_err_ff;
  assign PTR_ADDR = ptr_ff;
  assign PC_OUT = pc_ff;
  assign BANK = psw_ff[`PSW_RBS +: 3];

endmodule // cpu_register_banks

// file: testbench/cpu_register_banks_checker.sv
// checker for the register banks and internal address map
`timescale 1ns/1ns
`include "cpu_regs_consts.vh"
module cpu_regs_checker #(
  parameter RAM_BYTES = 2048
)(
  // clock and reset
  input logic CLK,
  input logic RST,
  // watched ports
  input logic REG_RD,
  input logic [7:0] REG_ADDR,
  input logic [23:0] REG_RDATA,
  input logic MAP_SEL,
  input logic [3:0] MAP_CODE,
  input logic MAP_FIXED,
  input logic MAP_HIGH,
  input logic MEM_RD,
  input logic MEM_WR,
  input logic [19:0] MEM_ADDR,
  input logic RAM_HIT,
  input logic EXT_STB,
  input logic HANG,
  input logic CTX_SW,
  input logic [2:0] CTX_BANK,
  input logic [2:0] BANK,
  input logic PC_LOAD,
  input logic [19:0] PC_TARGET,
  input logic [2:0] PC_STEP,
  input logic [19:0] PC_OUT
);
  localparam integer RLO_I = 65280 - RAM_BYTES;
  localparam [19:0] RLO = RLO_I[19:0];
  wire acc = (MEM_RD | MEM_WR) & !HANG;
  wire in_lo = MEM_ADDR >= RLO && MEM_ADDR < 20'h0_FF00;
  wire in_hi = MEM_ADDR >= (RLO | 20'hF_0000) && MEM_ADDR < 20'hF_FF00;
  wire ok_code = MAP_CODE == `MAP_LOW || MAP_CODE == `MAP_HIGH;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  //////////////////////////////////////
  a_map_first_take: assert property (!MAP_FIXED && MAP_SEL && ok_code
    |=> MAP_FIXED && MAP_HIGH == ($past(MAP_CODE) == `MAP_HIGH))
    else $error("map select not taken");
  a_map_bad_code: assert property (!MAP_FIXED && MAP_SEL && !ok_code
    |=> !MAP_FIXED) else $error("bad map code fixed the map");
  a_map_stays_put: assert property (MAP_FIXED
    |=> MAP_FIXED && $stable(MAP_HIGH)) else $error("map placement moved");
  a_ram_low_hit: assert property (acc && MAP_FIXED && !MAP_HIGH && in_lo
    |=> RAM_HIT) else $error("low ram not hit");
  a_ram_high_hit: assert property (acc && MAP_FIXED && MAP_HIGH && in_hi
    |=> RAM_HIT) else $error("high ram not hit");
  a_no_map_ext: assert property (acc && !MAP_FIXED
    |=> EXT_STB && !RAM_HIT) else $error("internal area before map");
  a_hang_holds: assert property (HANG
    |=> HANG && !RAM_HIT && !EXT_STB) else $error("hang left or access taken");
  a_pc_steps: assert property (!PC_LOAD
    |=> PC_OUT == $past(PC_OUT) + $past(PC_STEP)) else $error("pc step wrong");
  a_pc_loads: assert property (PC_LOAD
    |=> PC_OUT == $past(PC_TARGET)) else $error("pc load wrong");
  a_ctx_bank: assert property (CTX_SW
    |=> BANK == $past(CTX_BANK)) else $error("context bank wrong");
  a_psw_fixed_bits: assert property (REG_RD && REG_ADDR == `OFF_PSW
    |=> !REG_RDATA[1] && REG_RDATA[23:16] == 8'h00) else $error("psw bits");
  c_hang: cover property (HANG);
  c_high_map: cover property (MAP_FIXED && MAP_HIGH && RAM_HIT);
  c_ctx: cover property (CTX_SW);
endmodule // cpu_regs_checker
bind cpu_register_banks cpu_regs_checker #(.RAM_BYTES(RAM_BYTES)) u_chk (.*);

// file: testbench/cpu_register_banks_tb.sv
// self-checking bench for the register banks and address map
`timescale 1ns/1ns
`include "cpu_regs_consts.vh"
module cpu_register_banks_tb;
  logic CLK, RST, REG_WR, REG_RD, MAP_SEL, MEM_RD, MEM_WR, GPR_RD, GPR_WR;
  logic GPR_WORD, GPR_LEGACY, EXT_WR, CTX_SW, FLAG_WR, PC_LOAD;
  logic MAP_FIXED, MAP_HIGH, RAM_HIT, EXT_STB, SFR_STB, SFR_WE, SFR_ERR;
  logic HANG, GPR_ERR;
  logic [7:0] REG_ADDR, EXT_WDATA, FLAG_DATA, SFR_OFF;
  logic [23:0] REG_WDATA, REG_RDATA, PTR_ADDR;
  logic [3:0] MAP_CODE, GPR_IDX;
  logic [19:0] MEM_ADDR, PC_TARGET, PC_OUT;
  logic [1:0] MEM_SIZE, EXT_SEL, PTR_SEL;
  logic [15:0] MEM_WDATA, MEM_RDATA, SFR_WDATA, GPR_WDATA, GPR_RDATA;
  logic [2:0] CTX_BANK, PC_STEP, BANK;
  int n_fail, checks_done;
  cpu_register_banks u_cpu_register_banks (.*);
  initial
  begin
    CLK = 0;
    forever #5 CLK = ~CLK;
  end
  //////////////////////////////////////
  task chk(input string n, input logic [23:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task rst(input int n);
    @(posedge CLK);
    RST <= 1;
    repeat (n) @(posedge CLK);
    RST <= 0;
  endtask
  task rw(input logic [7:0] a, input logic [23:0] d);
    @(posedge CLK);
    REG_WR <= 1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [23:0] e);
    @(posedge CLK);
    REG_RD <= 1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 0;
    #1 chk("reg", REG_RDATA, e);
  endtask
  // outputs of the access stand one cycle; sampled just after the edge
  task mem(input logic w, input logic [19:0] a, input logic [1:0] s,
    input logic [15:0] d);
    @(posedge CLK);
    MEM_WR <= w;
    MEM_RD <= !w;
    MEM_ADDR <= a;
    MEM_SIZE <= s;
    MEM_WDATA <= d;
    @(posedge CLK);
    MEM_WR <= 0;
    MEM_RD <= 0;
    #1;
  endtask
  task gpr(input logic w, wd, lg, input logic [3:0] i, input logic [15:0] d);
    @(posedge CLK);
    GPR_WR <= w;
    GPR_RD <= !w;
    GPR_WORD <= wd;
    GPR_LEGACY <= lg;
    GPR_IDX <= i;
    GPR_WDATA <= d;
    @(posedge CLK);
    GPR_WR <= 0;
    GPR_RD <= 0;
    #1;
  endtask
  task msel(input logic [3:0] c);
    @(posedge CLK);
    MAP_SEL <= 1;
    MAP_CODE <= c;
    @(posedge CLK);
    MAP_SEL <= 0;
    #1;
  endtask
  //////////////////////////////////////
  task t_regs;
    rd(`OFF_PSW, 0);
    rd(`OFF_PC, 0);
    rd(8'h7F, 0);
    rw(`OFF_PSW, 24'h00_FFFF);
    rd(`OFF_PSW, 24'h00_17FD);
    chk("bank", BANK, 7);
    rw(`OFF_PC, 24'h00_1234);
    rd(`OFF_PC, 0);
    rw(`OFF_SP, 24'hFF_FFFF);
    rd(`OFF_SP, 24'hFF_FFFF);
    rd(`OFF_STAT, 24'h00_0002);
    rw(`OFF_SP, 0);
    rw(`OFF_PSW, 0);
    @(posedge CLK);
    FLAG_WR <= 1;
    FLAG_DATA <= 8'hFF;
    @(posedge CLK);
    FLAG_WR <= 0;
    rd(`OFF_PSW, 24'h00_00FD);
    rw(`OFF_PSW, 0);
  endtask
  task t_exec;
    @(posedge CLK);
    CTX_SW <= 1;
    CTX_BANK <= 5;
    @(posedge CLK);
    CTX_SW <= 0;
    #1 chk("bank", BANK, 5);
    rd(`OFF_PSW, 24'h00_0500);
    @(posedge CLK);
    PC_LOAD <= 1;
    PC_TARGET <= 20'hF_FFFE;
    @(posedge CLK);
    PC_LOAD <= 0;
    PC_STEP <= 3;
    @(posedge CLK);
    PC_STEP <= 0;
    #1 chk("pc", PC_OUT, 20'h0_0001);
  endtask
  task t_map_low;
    mem(0, 20'h0_F700, 2, 0);
    chk("ext", EXT_STB, 1);
    msel(4'h5);
    chk("fixed", MAP_FIXED, 0);
    msel(`MAP_LOW);
    chk("fixed", MAP_FIXED, 1);
    msel(`MAP_HIGH);
    chk("high", MAP_HIGH, 0);
    rd(`OFF_MAP, 24'h00_0001);
    mem(1, 20'h0_F700, 2, 16'h00A5);
    chk("hit", RAM_HIT, 1);
    mem(0, 20'h0_F700, 2, 0);
    chk("rdata", MEM_RDATA, 16'h00A5);
    mem(0, 20'h0_F6FF, 2, 0);
    chk("ext", EXT_STB, 1);
    mem(0, 20'h0_FEFF, 2, 0);
    chk("hit", RAM_HIT, 1);
  endtask
  task t_gpr;
    gpr(1, 1, 0, 4, 16'hBEEF);
    mem(0, 20'h0_FED4, 3, 0);
    chk("alias", MEM_RDATA, 16'hBEEF);
    gpr(0, 0, 0, 5, 0);
    chk("byte", GPR_RDATA, 16'h00BE);
    gpr(0, 1, 1, 4, 0);
    chk("lerr", GPR_ERR, 1);
    rw(`OFF_PSW, 24'h00_0520);
    gpr(0, 1, 1, 4, 0);
    chk("lword", GPR_RDATA, 16'hBEEF);
    gpr(0, 0, 1, 1, 0);
    chk("lbyte", GPR_RDATA, 16'h00BE);
    @(posedge CLK);
    EXT_WR <= 1;
    EXT_SEL <= 0;
    EXT_WDATA <= 8'h12;
    @(posedge CLK);
    EXT_WR <= 0;
    gpr(1, 1, 0, 8, 16'h3456);
    repeat (2) @(posedge CLK);
    #1 chk("ptr", PTR_ADDR, 24'h12_3456);
  endtask
  task t_sfr;
    mem(0, 20'h0_FF10, 3, 0);
    chk("sfr", SFR_STB, 1);
    chk("off", SFR_OFF, 8'h10);
    mem(1, 20'h0_FF02, 2, 16'h0005);
    chk("ro", SFR_ERR, 1);
    chk("rowe", SFR_WE, 0);
    mem(0, 20'h0_FF11, 3, 0);
    chk("odd", SFR_ERR, 1);
    mem(0, 20'h0_FF04, 2, 0);
    @(posedge CLK);
    #1 chk("hang", HANG, 1);
    mem(0, 20'h0_F700, 2, 0);
    chk("hit", RAM_HIT, 0);
    rst(2);
    #1 chk("hang", HANG, 0);
    chk("fixed", MAP_FIXED, 0);
  endtask
  task t_map_high;
    msel(`MAP_HIGH);
    chk("high", MAP_HIGH, 1);
    mem(1, 20'hF_F700, 2, 16'h005A);
    chk("hit", RAM_HIT, 1);
    mem(0, 20'hF_F700, 2, 0);
    chk("rdata", MEM_RDATA, 16'h005A);
    mem(0, 20'hF_FF10, 3, 0);
    chk("off", SFR_OFF, 8'h10);
    mem(1, 20'hF_FF00, 2, 16'h0033);
    chk("we", SFR_WE, 1);
    chk("wd", SFR_WDATA, 16'h0033);
    mem(0, 20'h0_F700, 2, 0);
    chk("ext", EXT_STB, 1);
  endtask
  //////////////////////////////////////
  initial
  begin
    {REG_WR, REG_RD, MAP_SEL, MEM_RD, MEM_WR, GPR_RD, GPR_WR, GPR_WORD,
      GPR_LEGACY, EXT_WR, CTX_SW, FLAG_WR, PC_LOAD, REG_ADDR, EXT_WDATA,
      FLAG_DATA, REG_WDATA, MAP_CODE, GPR_IDX, MEM_ADDR, PC_TARGET,
      MEM_SIZE, EXT_SEL, PTR_SEL, MEM_WDATA, GPR_WDATA, CTX_BANK,
      PC_STEP} = '0;
    RST = 1;
    repeat (16) @(posedge CLK);
    RST <= 0;
    t_regs;
    t_exec;
    t_map_low;
    t_gpr;
    t_sfr;
    t_map_high;
    test_done;
  end
  // a hang stops the run well past the expected length
  initial
  begin
    #200000;
    n_fail++;
    test_done;
  end
endmodule // cpu_register_banks_tb
